//--- verilog/lmc_pkg.sv
// Purpose: constants for the LED matrix control registers
// Assumes: register port from the two-wire slave, CLK at 125 MHz
// Notes: offsets are the device register addresses
// What this block does
// - Shutdown/test register resets to 0x02
// - Test covers only scan-limit segments
// - Test-all bit; disabled LEDs else open
// - Auto bit starts test on display start
// - Manual bit starts test on write
// - Init zero resets control state machine
// - Shutdown zero: outputs off, machine halts
// - Deadlocked bus resets two-wire interface
// - Timeout is (field+1) times 256 us
// - Watchdog register resets to 0xFF, enable
// - Clock-out code: 1M, 500k, 125k, 32k
// - Sync-out drives clock on sync pin
// - Sync-in takes clock from sync pin
// - Clock sync register resets to 0x00
// - Deadlock sets status bit 6
// - Open results: 1 good, 0 open
// - Test-running status reads 1
`default_nettype none
package lmc_pkg;
   // ----------------------------------------
   // Offsets and reset values
   // ----------------------------------------
   localparam logic [7:0] A_SHDN = 8'h09;
   localparam logic [7:0] A_WDOG = 8'h0a;
   localparam logic [7:0] A_CSYN = 8'h0b;
   localparam logic [7:0] A_ISTA = 8'h0e;
   localparam logic [7:0] A_STAT = 8'h0f;
   localparam logic [7:0] A_OPN0 = 8'h20;
   localparam logic [7:0] A_OPNL = 8'h37;
   localparam logic [7:0] R_SHDN = 8'h02;
   localparam logic [7:0] R_WDOG = 8'hff;
   localparam logic [7:0] R_CSYN = 8'h00;
   localparam logic [7:0] M_SHDN = 8'h1f;
   localparam logic [7:0] M_CSYN = 8'h0f;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int B_TALL = 4;
   localparam int B_AUTO = 3;
   localparam int B_MAN = 2;
   localparam int B_INIT = 1;
   localparam int B_SHDN = 0;
   localparam int B_WDEN = 0;
   localparam int B_TOLO = 1;
   localparam int B_CKLO = 2;
   localparam int B_SOUT = 1;
   localparam int B_SIN = 0;
   localparam int B_DLCK = 6;
   localparam int B_TON = 0;
   localparam int NSEG = 12;
   localparam int NLED = 11;
   localparam logic [3:0] SEG_LAST = 4'hb;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_NS = 8;
   localparam int CLK_KHZ = 125000;
   localparam int WD_UNIT_US = 256;
   localparam int WD_CYC = WD_UNIT_US * 1000 / CLK_NS;
   localparam int KHZ0 = 1000;
   localparam int KHZ1 = 500;
   localparam int KHZ2 = 125;
   localparam int KHZ3 = 32;
   localparam logic [11:0] CYC0 = 12'(CLK_KHZ / KHZ0);
   localparam logic [11:0] CYC1 = 12'(CLK_KHZ / KHZ1);
   localparam logic [11:0] CYC2 = 12'(CLK_KHZ / KHZ2);
   localparam logic [11:0] CYC3 = 12'(CLK_KHZ / KHZ3);
   typedef enum logic [1:0] {
      T_IDLE = 2'h0,
      T_RUN = 2'h1
   } lmc_tst_t;
endpackage
`default_nettype wire

//--- verilog/lmc_regs.sv
// Purpose: shutdown, test start, bus watchdog and clock sync registers
// Assumes: REG_* strobes come from the two-wire slave on CLK
// Notes: SYNC_CLK is the sync pin used as a clock input
`default_nettype none
module lmc_regs #(
   parameter int WD_CYC = lmc_pkg::WD_CYC
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // Register port
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   // Two-wire bus pins and interface reset
   input wire logic SCL_PIN,
   input wire logic SDA_PIN,
   output logic BUS_IF_RESET,
   output logic DEADLOCK_FLAG,
   // Display engine
   input wire logic DISPLAY_START,
   input wire logic [3:0] SCAN_LIMIT,
   output logic OUTPUTS_OFF,
   output logic CTRL_SM_RESET,
   output logic CTRL_SM_HALT,
   // LED test
   input wire logic [10:0] LED_OK,
   input wire logic [10:0] LED_EN,
   output logic [3:0] TEST_SEG,
   output logic TEST_RUNNING,
   // Sync pin and clock select
   input wire logic SYNC_CLK,
   output logic SYNC_O,
   output logic SYNC_OE_N,
   output logic OSC_EN,
   output logic SYS_TICK
);
   localparam logic [15:0] WD_LAST = 16'(WD_CYC - 1);

   logic [1:0] rst_q;
   logic rst_n;
   logic [7:0] shdn_q, wdog_q, csyn_q, rdata_q, rd_d;
   logic [1:0] bus_s1, bus_s2, bus_s3;
   logic wd_clr, fire, brst_q, dl_q;
   logic [15:0] pre_q;
   logic [6:0] unit_q;
   logic [1:0] lrst_q;
   logic ltog_q, e_s1, e_s2, e_s3, ext_tick;
   logic [11:0] div_q, per;
   logic int_tick, so_q, oen_q, osc_q;
   lmc_pkg::lmc_tst_t st_q;
   logic pend_q, go, start;
   logic [3:0] seg_q;
   logic [10:0] opn_q [lmc_pkg::NSEG];
   logic [4:0] oi;
   logic [3:0] limit;

   // Clock-out period for a frequency code
   function automatic logic [11:0] ck_per(input logic [1:0] c);
      case (c)
         2'h0: ck_per = lmc_pkg::CYC0;
         2'h1: ck_per = lmc_pkg::CYC1;
         2'h2: ck_per = lmc_pkg::CYC2;
         default: ck_per = lmc_pkg::CYC3;
      endcase
   endfunction

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   // Release is synchronous so no flop sees a runt reset edge
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) rst_q <= 2'h0;
      else rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   // Shutdown and test control
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) shdn_q <= lmc_pkg::R_SHDN;
      else if (REG_WR && REG_ADDR == lmc_pkg::A_SHDN) shdn_q <= REG_WDATA & lmc_pkg::M_SHDN;
   end

   // Watchdog control; bit 7 is the top bit of the 7-bit window
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) wdog_q <= lmc_pkg::R_WDOG;
      else if (REG_WR && REG_ADDR == lmc_pkg::A_WDOG) wdog_q <= REG_WDATA;
   end

   // Clock synchronisation control
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) csyn_q <= lmc_pkg::R_CSYN;
      else if (REG_WR && REG_ADDR == lmc_pkg::A_CSYN) csyn_q <= REG_WDATA & lmc_pkg::M_CSYN;
   end

   // Read mux; unmapped addresses read zero
   assign oi = 5'(REG_ADDR - lmc_pkg::A_OPN0);
   always_comb begin
      rd_d = 8'h00;
      if (REG_ADDR == lmc_pkg::A_SHDN) rd_d = shdn_q;
      else if (REG_ADDR == lmc_pkg::A_WDOG) rd_d = wdog_q;
      else if (REG_ADDR == lmc_pkg::A_CSYN) rd_d = csyn_q;
      else if (REG_ADDR == lmc_pkg::A_ISTA) rd_d[lmc_pkg::B_DLCK] = dl_q;
      else if (REG_ADDR == lmc_pkg::A_STAT) rd_d[lmc_pkg::B_TON] = (st_q == lmc_pkg::T_RUN);
      else if (REG_ADDR >= lmc_pkg::A_OPN0 && REG_ADDR <= lmc_pkg::A_OPNL) begin
         if (oi[0]) rd_d = {5'h00, opn_q[oi[4:1]][10:8]};
         else rd_d = opn_q[oi[4:1]][7:0];
      end
   end

   // Read data holds until the next read
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) rdata_q <= 8'h00;
      else if (REG_RD) rdata_q <= rd_d;
   end
   assign REG_RDATA = rdata_q;

   // ----------------------------------------
   // Bus watchdog
   // ----------------------------------------
   // Pin synchronisers, third stage only for change detection
   for (genvar p = 0; p < 2; p++) begin : g_bsync
      always_ff @(posedge CLK or negedge rst_n) begin
         if (!rst_n) begin
            bus_s1[p] <= 1'b1;
            bus_s2[p] <= 1'b1;
            bus_s3[p] <= 1'b1;
         end else begin
            bus_s1[p] <= p == 0 ? SCL_PIN : SDA_PIN;
            bus_s2[p] <= bus_s1[p];
            bus_s3[p] <= bus_s2[p];
         end
      end
   end

   // activity restart
   // An idle bus (both high) is no deadlock, so it never counts
   assign wd_clr = (bus_s2 != bus_s3) || (&bus_s2) || !wdog_q[lmc_pkg::B_WDEN] ||
                   (REG_WR && REG_ADDR == lmc_pkg::A_WDOG);
   assign fire = !wd_clr && pre_q == WD_LAST && unit_q == wdog_q[7:lmc_pkg::B_TOLO];

   // Prescaler of 256 us units and unit counter
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= 16'h0000;
         unit_q <= 7'h00;
      end else if (wd_clr || fire) begin
         pre_q <= 16'h0000;
         unit_q <= 7'h00;
      end else if (pre_q == WD_LAST) begin
         pre_q <= 16'h0000;
         unit_q <= unit_q + 7'h01;
      end else begin
         pre_q <= pre_q + 16'h0001;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) brst_q <= 1'b0;
      else brst_q <= fire;
   end
   assign BUS_IF_RESET = brst_q;

   // deadlock flag
   // Set wins over the clear-on-read of the status register
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) dl_q <= 1'b0;
      else if (fire) dl_q <= 1'b1;
      else if (REG_RD && REG_ADDR == lmc_pkg::A_ISTA) dl_q <= 1'b0;
   end
   assign DEADLOCK_FLAG = dl_q;

   // ----------------------------------------
   // Sync pin clock domain
   // ----------------------------------------
   // Own reset release so the first edge after reset is clean
   always_ff @(posedge SYNC_CLK or negedge RESETN) begin
      if (!RESETN) lrst_q <= 2'h0;
      else lrst_q <= {lrst_q[0], 1'b1};
   end

   // Toggle per input edge; crosses as an event
   always_ff @(posedge SYNC_CLK or negedge RESETN) begin
      if (!RESETN) ltog_q <= 1'b0;
      else if (lrst_q[1]) ltog_q <= ~ltog_q;
   end

   // Toggle synchroniser into CLK
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         e_s1 <= 1'b0;
         e_s2 <= 1'b0;
         e_s3 <= 1'b0;
      end else begin
         e_s1 <= ltog_q;
         e_s2 <= e_s1;
         e_s3 <= e_s2;
      end
   end
   // Limitation: external clock must stay below CLK/4
   assign ext_tick = e_s2 ^ e_s3;

   // ----------------------------------------
   // Clock source and clock out
   // ----------------------------------------
   // frequency code
   assign per = ck_per(csyn_q[lmc_pkg::B_CKLO +: 2]);

   // Oscillator model; stopped while the pin is the clock source
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) div_q <= 12'h000;
      else if (csyn_q[lmc_pkg::B_SIN]) div_q <= 12'h000;
      else if (div_q >= per - 12'h001) div_q <= 12'h000;
      else div_q <= div_q + 12'h001;
   end
   assign int_tick = !csyn_q[lmc_pkg::B_SIN] && div_q >= per - 12'h001;

   // sync-in wins if the host sets both, pin never fights
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         so_q <= 1'b0;
         oen_q <= 1'b1;
         osc_q <= 1'b1;
      end else begin
         so_q <= csyn_q[lmc_pkg::B_SOUT] && !csyn_q[lmc_pkg::B_SIN] && div_q < {1'b0, per[11:1]};
         oen_q <= !(csyn_q[lmc_pkg::B_SOUT] && !csyn_q[lmc_pkg::B_SIN]);
         osc_q <= !csyn_q[lmc_pkg::B_SIN];
      end
   end
   assign SYNC_O = so_q;
   assign SYNC_OE_N = oen_q;
   assign OSC_EN = osc_q;
   assign SYS_TICK = csyn_q[lmc_pkg::B_SIN] ? ext_tick : int_tick;

   // ----------------------------------------
   // Control and LED test
   // ----------------------------------------
   // init reset
   assign CTRL_SM_RESET = !shdn_q[lmc_pkg::B_INIT];
   assign CTRL_SM_HALT = !shdn_q[lmc_pkg::B_SHDN];
   assign OUTPUTS_OFF = !shdn_q[lmc_pkg::B_SHDN];

   assign start = (REG_WR && REG_ADDR == lmc_pkg::A_SHDN && REG_WDATA[lmc_pkg::B_MAN]) ||
                  (DISPLAY_START && shdn_q[lmc_pkg::B_AUTO]);
   // Starts wait for normal operation so the new bits apply
   assign go = st_q == lmc_pkg::T_IDLE && pend_q && shdn_q[lmc_pkg::B_INIT] && shdn_q[lmc_pkg::B_SHDN];

   // Pending start; a new request wins over consumption
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) pend_q <= 1'b0;
      else if (start) pend_q <= 1'b1;
      else if (go || !shdn_q[lmc_pkg::B_INIT]) pend_q <= 1'b0;
   end

   assign limit = SCAN_LIMIT > lmc_pkg::SEG_LAST ? lmc_pkg::SEG_LAST : SCAN_LIMIT;

   // Test sequencer, one segment per system tick
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) st_q <= lmc_pkg::T_IDLE;
      else if (!shdn_q[lmc_pkg::B_INIT]) st_q <= lmc_pkg::T_IDLE;
      else begin
         case (st_q)
            lmc_pkg::T_IDLE: begin
               if (go) st_q <= lmc_pkg::T_RUN;
            end
            lmc_pkg::T_RUN: begin
               if (shdn_q[lmc_pkg::B_SHDN] && SYS_TICK && seg_q == limit) st_q <= lmc_pkg::T_IDLE;
            end
            default: st_q <= lmc_pkg::T_IDLE;
         endcase
      end
   end

   // Segment index
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) seg_q <= 4'h0;
      else if (go) seg_q <= 4'h0;
      else if (st_q == lmc_pkg::T_RUN && shdn_q[lmc_pkg::B_SHDN] && SYS_TICK && seg_q != limit)
         seg_q <= seg_q + 4'h1;
   end
   assign TEST_SEG = seg_q;
   assign TEST_RUNNING = st_q == lmc_pkg::T_RUN;

   // Results; untested segments stay 0 and so read as open
   for (genvar s = 0; s < lmc_pkg::NSEG; s++) begin : g_res
      always_ff @(posedge CLK or negedge rst_n) begin
         if (!rst_n) opn_q[s] <= 11'h000;
         else if (go) opn_q[s] <= 11'h000;
         else if (st_q == lmc_pkg::T_RUN && shdn_q[lmc_pkg::B_SHDN] && SYS_TICK && seg_q == 4'(s))
            opn_q[s] <= LED_OK & (shdn_q[lmc_pkg::B_TALL] ? 11'h7ff : LED_EN);
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   int quiet;
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) quiet <= 0;
      else if (wd_clr || fire) quiet <= 0;
      else quiet <= quiet + 1;
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!rst_n);

   chk_shdn_reset: assert property ($rose(rst_n) |-> shdn_q == lmc_pkg::R_SHDN)
      else $error("shutdown register reset value wrong");
   chk_wdog_reset: assert property ($rose(rst_n) |-> wdog_q == lmc_pkg::R_WDOG && csyn_q == 8'h00)
      else $error("watchdog or sync register reset value wrong");
   chk_scan_stop: assert property (TEST_RUNNING && !CTRL_SM_HALT && !CTRL_SM_RESET && SYS_TICK
      && seg_q == limit |=> !TEST_RUNNING)
      else $error("test did not stop at scan limit");
   chk_mask_open: assert property (TEST_RUNNING && !CTRL_SM_HALT && !CTRL_SM_RESET && SYS_TICK
      && !shdn_q[4] |=> (opn_q[$past(seg_q)] & ~$past(LED_EN)) == 11'h000)
      else $error("disabled LED not reported open");
   chk_auto_go: assert property (DISPLAY_START && shdn_q == 8'h0b && !TEST_RUNNING && !REG_WR
      |-> ##2 TEST_RUNNING)
      else $error("auto test did not start");
   chk_manual_go: assert property (REG_WR && REG_ADDR == 8'h09 && REG_WDATA[2:0] == 3'h7 && !TEST_RUNNING
      |-> ##2 TEST_RUNNING)
      else $error("manual test did not start");
   chk_init_idle: assert property (CTRL_SM_RESET |=> !TEST_RUNNING)
      else $error("init zero did not reset test");
   chk_wd_window: assert property (fire |-> quiet == (int'(wdog_q[7:1]) + 1) * WD_CYC - 1)
      else $error("watchdog fired at wrong time");
   chk_dl_flag: assert property (fire |=> BUS_IF_RESET && DEADLOCK_FLAG)
      else $error("deadlock not flagged");
   chk_sync_drive: assert property (!SYNC_OE_N |-> $past(csyn_q[1:0]) == 2'h2)
      else $error("sync pin driven without sync out");
   chk_run_status: assert property (REG_RD && REG_ADDR == 8'h0f && TEST_RUNNING |=> REG_RDATA[0])
      else $error("running status not read back");

   cov_test_done: cover property (TEST_RUNNING ##1 !TEST_RUNNING);
   cov_wd_fire: cover property (BUS_IF_RESET);
   cov_ext_tick: cover property (!OSC_EN && SYS_TICK);
   cov_auto: cover property (DISPLAY_START && shdn_q[3]);
endmodule
`default_nettype wire

//--- verif/lmc_host.sv
// Purpose: far-side model: two-wire bus pin levels and external sync clock
// Assumes: bus pins have pull-ups, so a released line reads high
// Notes: the sync clock stands low while switched off
`default_nettype none
module lmc_host (
   // Bench controls
   input wire logic clk,
   input wire logic stick,
   input wire logic wiggle,
   input wire logic clk_on,
   // Pins toward the device
   output logic scl_pin,
   output logic sda_pin,
   output logic sync_clk
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [4:0] div_q;
   // Idle bus at start, counter defined
   initial begin
      div_q = 5'h00;
      scl_pin = 1'b1;
      sda_pin = 1'b1;
   end
   // data line stuck low
   // SCL toggles only when asked, to show bus activity
   always @(posedge clk) begin
      div_q <= div_q + 5'h01;
      sda_pin <= !stick;
      if (!stick || !wiggle) begin
         scl_pin <= 1'b1;
      end else if (div_q == 5'h00) begin
         scl_pin <= !scl_pin;
      end
   end
   // external clock, 160 ns
   // Odd start offset keeps its edges 1 ns ahead of the rising system clock edges
   initial begin
      sync_clk = 1'b0;
      #3;
      forever begin
         #80;
         sync_clk = clk_on ? !sync_clk : 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Purpose: self-checking bench for the LED matrix control registers
// Assumes: watchdog unit shortened to 16 cycles
// Notes: each scenario is one task
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, resetn, reg_wr, reg_rd, scl, sda, bus_rst, dl_flag, disp_start;
   logic outs_off, sm_rst, sm_halt, test_run, sync_clk, sync_o, sync_oe_n, osc_en, sys_tick;
   logic stick, wiggle, clk_on;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [3:0] scan_lim, test_seg;
   logic [10:0] led_ok, led_en;
   int err_total, checks_done, n, m;
   // ----------------------------------------
   // Device and far side
   // ----------------------------------------
   lmc_regs #(.WD_CYC(16)) dut (.CLK(clk), .RESETN(resetn), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .SCL_PIN(scl),
      .SDA_PIN(sda), .BUS_IF_RESET(bus_rst), .DEADLOCK_FLAG(dl_flag), .DISPLAY_START(disp_start),
      .SCAN_LIMIT(scan_lim), .OUTPUTS_OFF(outs_off), .CTRL_SM_RESET(sm_rst), .CTRL_SM_HALT(sm_halt),
      .LED_OK(led_ok), .LED_EN(led_en), .TEST_SEG(test_seg), .TEST_RUNNING(test_run),
      .SYNC_CLK(sync_clk), .SYNC_O(sync_o), .SYNC_OE_N(sync_oe_n), .OSC_EN(osc_en), .SYS_TICK(sys_tick));
   lmc_host host (.clk(clk), .stick(stick), .wiggle(wiggle), .clk_on(clk_on), .scl_pin(scl),
      .sda_pin(sda), .sync_clk(sync_clk));
   // 125 MHz system clock
   initial begin
      clk = 1'b0;
      forever #4 clk = !clk;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("register %h", a), {8'h00, exp}, {8'h00, reg_rdata});
   endtask
   // Counts edges until the signal shows the level; a spent bound ends the run
   task automatic wait_lvl(ref logic s, input logic v, input int lim, output int k);
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (s !== v && k < lim);
      if (s !== v) begin
         chk("bounded wait", 16'h0001, 16'h0000);
         wrap_up();
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic sc_reset;
      rd(8'h09, 8'h02);
      rd(8'h0a, 8'hff);
      rd(8'h0b, 8'h00);
      rd(8'h05, 8'h00);
      chk("outputs off", 16'h1, {15'h0, outs_off});
      chk("osc enable", 16'h1, {15'h0, osc_en});
      chk("sync oe_n", 16'h1, {15'h0, sync_oe_n});
      wr(8'h0b, 8'hfc);
      rd(8'h0b, 8'h0c);
   endtask
   task automatic sc_init_shdn(input logic [7:0] v);
      wr(8'h09, v);
      @(posedge clk);
      #1;
      chk("sm reset", {15'h0, !v[1]}, {15'h0, sm_rst});
      chk("sm halt", {15'h0, !v[0]}, {15'h0, sm_halt});
      chk("outputs off", {15'h0, !v[0]}, {15'h0, outs_off});
   endtask
   task automatic sc_test;
      // Design inputs change only on a clock edge
      @(posedge clk);
      scan_lim <= 4'h2;
      led_ok <= 11'h5a5;
      led_en <= 11'h3f0;
      wr(8'h09, 8'h17);
      wait_lvl(test_run, 1'b1, 4, n);
      chk("first segment", 16'h0, {12'h0, test_seg});
      rd(8'h0f, 8'h01);
      wait_lvl(test_run, 1'b0, 20000, n);
      chk("last segment", 16'h2, {12'h0, test_seg});
      rd(8'h20, 8'ha5);
      rd(8'h21, 8'h05);
      rd(8'h25, 8'h05);
      rd(8'h26, 8'h00);
      wr(8'h09, 8'h0b);
      @(posedge clk);
      disp_start <= 1'b1;
      @(posedge clk);
      disp_start <= 1'b0;
      wait_lvl(test_run, 1'b1, 4, n);
      wait_lvl(test_run, 1'b0, 20000, n);
      rd(8'h20, 8'ha0);
      rd(8'h21, 8'h01);
      // Init cleared in mid-run must stop the sequencer at once
      wr(8'h09, 8'h07);
      wait_lvl(test_run, 1'b1, 4, n);
      wr(8'h09, 8'h01);
      @(posedge clk);
      #1;
      chk("init stops test", 16'h0, {15'h0, test_run});
   endtask
   task automatic sc_watchdog;
      wr(8'h0a, 8'h05);
      stick <= 1'b1;
      wait_lvl(bus_rst, 1'b1, 80, n);
      chk("deadlock delay", 16'h1, {15'h0, n >= 49 && n <= 58});
      chk("deadlock flag", 16'h1, {15'h0, dl_flag});
      rd(8'h0e, 8'h40);
      stick <= 1'b0;
      rd(8'h0e, 8'h00);
      stick <= 1'b1;
      wiggle <= 1'b1;
      m = 0;
      // Sample after the edge so the pulse is seen where it stands
      repeat (200) begin
         @(posedge clk);
         #1;
         m += bus_rst;
      end
      chk("reset during activity", 16'h0, 16'(m));
      wiggle <= 1'b0;
      wr(8'h0a, 8'h04);
      m = 0;
      repeat (200) begin
         @(posedge clk);
         #1;
         m += bus_rst;
      end
      chk("reset while off", 16'h0, 16'(m));
      stick <= 1'b0;
   endtask
   task automatic sc_clk_out;
      logic [11:0] cyc [4];
      cyc = '{lmc_pkg::CYC0, lmc_pkg::CYC1, lmc_pkg::CYC2, lmc_pkg::CYC3};
      for (int c = 0; c < 4; c++) begin
         wr(8'h0b, {4'h0, 2'(c), 2'b10});
         wait_lvl(sync_o, 1'b0, 8000, n);
         wait_lvl(sync_o, 1'b1, 8000, n);
         wait_lvl(sync_o, 1'b0, 8000, n);
         wait_lvl(sync_o, 1'b1, 8000, m);
         chk("clock out period", {4'h0, cyc[c]}, 16'(n + m));
         chk("sync oe_n", 16'h0, {15'h0, sync_oe_n});
      end
   endtask
   task automatic sc_sync_in;
      clk_on <= 1'b1;
      wr(8'h0b, 8'h01);
      repeat (60) @(posedge clk);
      m = 0;
      repeat (800) begin
         @(posedge clk);
         #1;
         m += sys_tick;
      end
      chk("external ticks", 16'h1, {15'h0, m >= 38 && m <= 41});
      chk("osc enable", 16'h0, {15'h0, osc_en});
      chk("sync oe_n", 16'h1, {15'h0, sync_oe_n});
      clk_on <= 1'b0;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      err_total = 0;
      checks_done = 0;
      resetn = 1'b0;
      {reg_wr, reg_rd, disp_start, stick, wiggle, clk_on} = 6'h00;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      scan_lim = 4'h0;
      led_ok = 11'h000;
      led_en = 11'h000;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      sc_reset();
      sc_init_shdn(8'h00);
      sc_init_shdn(8'h03);
      sc_test();
      sc_watchdog();
      sc_clk_out();
      sc_sync_in();
      wrap_up();
   end
endmodule
`default_nettype wire
